// [include/core_sfr_regs.svh]
`ifndef CORE_SFR_REGS_SVH
`define CORE_SFR_REGS_SVH

// Region geometry
`define SFR_REGION_FIRST 16'h0000
`define SFR_REGION_LAST 16'h07FF
`define SFR_BLOCK_BYTES 32
`define SFR_BLOCK_SHIFT 5
`define SFR_BLOCK_COUNT 64
`define SFR_BLOCK_MAP 64'h0C77_0000_03FF_FF7F
`define SFR_EMPTY_FIRST 16'h0400
`define SFR_EMPTY_LAST 16'h05FF

// Register count and indices
`define CORE_REG_COUNT 25
`define IDX_WORKING_REG_15 5'h0F
`define IDX_PC_HIGH_BYTE 5'h12
`define IDX_CPU_STATUS_FLAGS 5'h16
`define IDX_CORE_CONTROL 5'h17

// Register offsets
`define OFS_WORKING_REG_0 16'h0000
`define OFS_WORKING_REG_1 16'h0002
`define OFS_WORKING_REG_2 16'h0004
`define OFS_WORKING_REG_3 16'h0006
`define OFS_WORKING_REG_4 16'h8000
`define OFS_WORKING_REG_5 16'h000A
`define OFS_WORKING_REG_6 16'h000C
`define OFS_WORKING_REG_7 16'h000E
`define OFS_WORKING_REG_8 16'h0010
`define OFS_WORKING_REG_9 16'h0012
`define OFS_WORKING_REG_10 16'h0014
`define OFS_WORKING_REG_11 16'h0016
`define OFS_WORKING_REG_12 16'h0018
`define OFS_WORKING_REG_13 16'h001A
`define OFS_WORKING_REG_14 16'h001C
`define OFS_WORKING_REG_15 16'h001E
`define OFS_STACK_LIMIT 16'h0020
`define OFS_PC_LOW_WORD 16'h002E
`define OFS_PC_HIGH_BYTE 16'h0030
`define OFS_TABLE_PAGE 16'h0032
`define OFS_PROGRAM_WINDOW_PAGE 16'h0034
`define OFS_REPEAT_LOOP_COUNT 16'h0036
`define OFS_CPU_STATUS_FLAGS 16'h0042
`define OFS_CORE_CONTROL 16'h0044
`define OFS_INTERRUPT_DISABLE_COUNT 16'h0052

// Implemented bit masks
`define MASK_FULL 16'hFFFF
`define MASK_LOW_BYTE 16'h00FF
`define MASK_CPU_STATUS_FLAGS 16'h01FF
`define MASK_CORE_CONTROL 16'h000C
`define MASK_INTERRUPT_DISABLE_COUNT 16'h3FFF

// Field positions
`define BIT_DIGIT_CARRY 8
`define BIT_PRIORITY_HI 7
`define BIT_PRIORITY_LO 5
`define BIT_REPEAT_ACTIVE 4
`define BIT_PRIORITY_LEVEL_BIT3 3
`define BIT_PROGRAM_WINDOW_ENABLE 2

// Reset values
`define RST_ZERO 16'h0000
`define RST_WORKING_REG_15 16'h0800
`define RST_UNDEFINED 16'h0000

`endif

// [include/core_sfr_pkg.sv]
package core_sfr_pkg;

  typedef logic [15:0] sfr_word_t;
  typedef logic [4:0] reg_idx_t;
  typedef logic [5:0] block_idx_t;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0,
    ACC_READ = 2'h1,
    ACC_WRITE = 2'h3
  } acc_kind_t;

endpackage

// [hdl/byte_lane_merge.sv]
`timescale 1ns/1ns
module byte_lane_merge
  import core_sfr_pkg::*;
(
  // Word being updated
  input wire sfr_word_t old_word,
  // Incoming write
  input wire sfr_word_t wr_word,
  input wire logic byte_access,
  input wire logic high_lane,
  // Result
  output sfr_word_t merged_word
);

  always_comb begin
    merged_word = wr_word;
    if (byte_access) begin
      if (high_lane) begin
        merged_word = {wr_word[7:0], old_word[7:0]};
      end else begin
        merged_word = {old_word[15:8], wr_word[7:0]};
      end
    end
  end

endmodule // byte_lane_merge

// [hdl/core_sfr_space_decoder.sv]
`timescale 1ns/1ns
`include "core_sfr_regs.svh"
module core_sfr_space_decoder
  import core_sfr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data-space access from the core
  input wire sfr_word_t addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic byte_access,
  input wire sfr_word_t wr_data,
  // Read answer
  output sfr_word_t rd_data,
  output logic rd_valid,
  output logic sfr_hit,
  output logic addr_error,
  // Core control state
  output logic program_window_enable,
  output logic [3:0] priority_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map tables

  localparam int NREG = `CORE_REG_COUNT;

  localparam sfr_word_t REG_ADDR [NREG] = '{
    `OFS_WORKING_REG_0, `OFS_WORKING_REG_1, `OFS_WORKING_REG_2, `OFS_WORKING_REG_3,
    `OFS_WORKING_REG_4, `OFS_WORKING_REG_5, `OFS_WORKING_REG_6, `OFS_WORKING_REG_7,
    `OFS_WORKING_REG_8, `OFS_WORKING_REG_9, `OFS_WORKING_REG_10, `OFS_WORKING_REG_11,
    `OFS_WORKING_REG_12, `OFS_WORKING_REG_13, `OFS_WORKING_REG_14, `OFS_WORKING_REG_15,
    `OFS_STACK_LIMIT, `OFS_PC_LOW_WORD, `OFS_PC_HIGH_BYTE, `OFS_TABLE_PAGE,
    `OFS_PROGRAM_WINDOW_PAGE, `OFS_REPEAT_LOOP_COUNT, `OFS_CPU_STATUS_FLAGS,
    `OFS_CORE_CONTROL, `OFS_INTERRUPT_DISABLE_COUNT
  };

  // Implemented bits per register
  localparam sfr_word_t REG_MASK [NREG] = '{
    `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL,
    `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL,
    `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL,
    `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL,
    `MASK_FULL, `MASK_FULL, `MASK_LOW_BYTE, `MASK_LOW_BYTE,
    `MASK_LOW_BYTE, `MASK_FULL, `MASK_CPU_STATUS_FLAGS,
    `MASK_CORE_CONTROL, `MASK_INTERRUPT_DISABLE_COUNT
  };

  // Reset values per register
  localparam sfr_word_t REG_RST [NREG] = '{
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_WORKING_REG_15,
    `RST_UNDEFINED, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_UNDEFINED, `RST_ZERO,
    `RST_ZERO, `RST_UNDEFINED
  };

  localparam logic [`SFR_BLOCK_COUNT-1:0] BLOCK_MAP = `SFR_BLOCK_MAP;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  sfr_word_t addr_word;
  logic in_region;
  logic misaligned;
  logic hit_any;
  reg_idx_t hit_idx;
  block_idx_t block_idx;
  logic block_implemented;
  sfr_word_t sel_word;
  sfr_word_t read_value;
  sfr_word_t merged_word;
  logic write_ok;
  acc_kind_t acc_kind;

  assign addr_word = {addr[15:1], 1'b0};
  assign in_region = (addr <= `SFR_REGION_LAST);
  assign block_idx = addr[`SFR_BLOCK_SHIFT+5:`SFR_BLOCK_SHIFT];
  assign block_implemented = in_region && BLOCK_MAP[block_idx];
  assign misaligned = !byte_access && addr[0];

  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < NREG; i++) begin
      if (addr_word == REG_ADDR[i]) begin
        hit_any = 1'b1;
        hit_idx = 5'(i);
      end
    end
  end

  always_comb begin
    acc_kind = ACC_IDLE;
    if (wr_en) begin
      acc_kind = ACC_WRITE;
    end else if (rd_en) begin
      acc_kind = ACC_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  sfr_word_t core_reg [NREG];
  sfr_word_t core_next [NREG];

  // Unmapped addresses give zero
  assign sel_word = hit_any ? core_reg[hit_idx] : 16'h0000;
  assign write_ok = wr_en && hit_any && !misaligned;

  byte_lane_merge u_lane_merge (
    .old_word(sel_word),
    .wr_word(wr_data),
    .byte_access(byte_access),
    .high_lane(addr[0]),
    .merged_word(merged_word)
  );

  generate
    for (genvar g = 0; g < NREG; g++) begin : g_entry
      always_comb begin
        core_next[g] = core_reg[g];
        if (write_ok && (hit_idx == 5'(g))) begin
          core_next[g] = merged_word & REG_MASK[g];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          core_reg[g] <= REG_RST[g];
        end else begin
          core_reg[g] <= core_next[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read answer

  sfr_word_t rd_data_reg;
  sfr_word_t rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic sfr_hit_reg;
  logic sfr_hit_next;
  logic addr_error_reg;
  logic addr_error_next;

  always_comb begin
    read_value = sel_word;
    if (byte_access) begin
      read_value = {8'h00, addr[0] ? sel_word[15:8] : sel_word[7:0]};
    end
  end

  always_comb begin
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    sfr_hit_next = sfr_hit_reg;
    addr_error_next = 1'b0;
    if (acc_kind == ACC_READ) begin
      rd_data_next = read_value;
      rd_valid_next = 1'b1;
    end
    if (rd_en || wr_en) begin
      sfr_hit_next = block_implemented;
      addr_error_next = misaligned;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
      sfr_hit_reg <= 1'b0;
      addr_error_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      sfr_hit_reg <= sfr_hit_next;
      addr_error_reg <= addr_error_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign sfr_hit = sfr_hit_reg;
  assign addr_error = addr_error_reg;
  assign program_window_enable = core_reg[`IDX_CORE_CONTROL][`BIT_PROGRAM_WINDOW_ENABLE];
  assign priority_level = {core_reg[`IDX_CORE_CONTROL][`BIT_PRIORITY_LEVEL_BIT3],
                           core_reg[`IDX_CPU_STATUS_FLAGS][`BIT_PRIORITY_HI:`BIT_PRIORITY_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic seen_reg;
  logic seen_next;

  assign seen_next = 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_OUTSIDE_REGION: assert property (
    (rd_en && !wr_en && (addr > `SFR_REGION_LAST) && (addr_word != `OFS_WORKING_REG_4))
      |=> (rd_valid && rd_data == 16'h0000 && !sfr_hit)
  ) else $error("read outside region not zero");

  AST_UNUSED_ADDR: assert property (
    (rd_en && !wr_en && !byte_access && addr == 16'h0022) |=> (rd_data == 16'h0000)
  ) else $error("unused address did not read zero");

  AST_BLOCK_FLAG: assert property (
    (rd_en && addr == `OFS_CPU_STATUS_FLAGS) |=> sfr_hit
  ) else $error("core block not flagged implemented");

  AST_EMPTY_BLOCKS: assert property (
    (rd_en && !wr_en && addr >= `SFR_EMPTY_FIRST && addr <= `SFR_EMPTY_LAST)
      |=> (rd_data == 16'h0000 && !sfr_hit)
  ) else $error("empty block read not zero");

  AST_WREG_WRITE_READ: assert property (
    (wr_en && !byte_access && addr == `OFS_WORKING_REG_2) ##1 (!wr_en && !rd_en)
      ##1 (rd_en && !wr_en && !byte_access && addr == `OFS_WORKING_REG_2)
      |=> (rd_data == $past(wr_data, 3))
  ) else $error("working register lost written word");

  AST_W15_RESET: assert property (
    !seen_reg |-> (core_reg[`IDX_WORKING_REG_15] == `RST_WORKING_REG_15 && core_reg[0] == 16'h0000)
  ) else $error("reset values wrong");

  AST_STATUS_BITS: assert property (
    (rd_en && !wr_en && !byte_access && addr == `OFS_CPU_STATUS_FLAGS)
      |=> (rd_data[15:9] == 7'h00 && rd_data[7:5] == priority_level[2:0])
  ) else $error("status register layout broken");

  AST_CORE_CONTROL_BITS: assert property (
    (rd_en && !wr_en && !byte_access && addr == `OFS_CORE_CONTROL)
      |=> ((rd_data & 16'hFFF3) == 16'h0000 && rd_data[2] == program_window_enable)
  ) else $error("core control unimplemented bit set");

  AST_PC_HIGH_BYTE: assert property (
    (wr_en && !byte_access && addr == `OFS_PC_HIGH_BYTE)
      |=> (core_reg[`IDX_PC_HIGH_BYTE] == {8'h00, $past(wr_data[7:0])})
  ) else $error("program counter high upper byte kept");

  AST_BYTE_LANE: assert property (
    (wr_en && byte_access && addr == 16'h0003)
      |=> (core_reg[1][7:0] == $past(core_reg[1][7:0]) && core_reg[1][15:8] == $past(wr_data[7:0]))
  ) else $error("byte write disturbed other lane");

  AST_BYTE_LOW_LANE: assert property (
    (wr_en && byte_access && addr == 16'h0002)
      |=> (core_reg[1][15:8] == $past(core_reg[1][15:8]) && core_reg[1][7:0] == $past(wr_data[7:0]))
  ) else $error("low byte write disturbed other lane");

  AST_BYTE_READ_TOP: assert property (
    (rd_en && !wr_en && byte_access) |=> (rd_valid && rd_data[15:8] == 8'h00)
  ) else $error("byte read upper lane not zero");

  AST_EMPTY_NO_WRITE: assert property (
    (wr_en && addr >= `SFR_EMPTY_FIRST && addr <= `SFR_EMPTY_LAST) |-> !write_ok
  ) else $error("write into empty block accepted");

  AST_MISALIGNED: assert property (
    (wr_en && !byte_access && addr == 16'h0003)
      |=> (addr_error && core_reg[1] == $past(core_reg[1]))
  ) else $error("misaligned write not suppressed");

  AST_DISABLE_COUNT_BITS: assert property (
    (wr_en && !byte_access && addr == `OFS_INTERRUPT_DISABLE_COUNT) ##1 (!wr_en && !rd_en)
      ##1 (rd_en && !wr_en && !byte_access && addr == `OFS_INTERRUPT_DISABLE_COUNT)
      |=> (rd_data[15:14] == 2'h0)
  ) else $error("unimplemented bits read back");

endmodule // core_sfr_space_decoder

// [tb/core_access_model.sv]
`timescale 1ns/1ns
module core_access_model
  import core_sfr_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Access request
  output sfr_word_t addr,
  output logic rd_en,
  output logic wr_en,
  output logic byte_access,
  output sfr_word_t wr_data,
  // Read answer
  input wire sfr_word_t rd_data,
  input wire logic rd_valid
);
  initial begin
    addr = 16'h0000;
    rd_en = 1'b0;
    wr_en = 1'b0;
    byte_access = 1'b0;
    wr_data = 16'h0000;
  end

  // Write held for one taking edge, then wr_en dropped and addr, wr_data driven inverted
  task automatic put(input sfr_word_t a, input sfr_word_t d, input logic b);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    byte_access <= b;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
    #1;
  endtask

  // Read, answer sampled 1 ns after the taking edge
  task automatic get(input sfr_word_t a, input logic b, output sfr_word_t d, output logic v);
    @(posedge sys_clk);
    addr <= a;
    byte_access <= b;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule // core_access_model

// [tb/tb_core_sfr_space_decoder.sv]
`timescale 1ns/1ns
module tb_core_sfr_space_decoder
  import core_sfr_pkg::*;
;
  logic sys_clk, rst_n, rd_en, wr_en, byte_access, rd_valid, sfr_hit, addr_error, program_window_enable;
  sfr_word_t addr, wr_data, rd_data, d, q, old, e;
  logic [3:0] priority_level;
  logic v;
  int i, bad_count, check_count;
  sfr_word_t regs [25] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h8000, 16'h000A, 16'h000C,
    16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E,
    16'h002E, 16'h0030, 16'h0032, 16'h0034, 16'h0042, 16'h0044, 16'h0020, 16'h0036, 16'h0052};

  core_sfr_space_decoder i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .byte_access(byte_access), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .sfr_hit(sfr_hit), .addr_error(addr_error),
    .program_window_enable(program_window_enable), .priority_level(priority_level));
  core_access_model i_core (.sys_clk(sys_clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
    .byte_access(byte_access), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  ////////////////////////////////////////////////////////////
  // Clock and helpers
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  function automatic sfr_word_t mask_of(input sfr_word_t a);
    case (a)
      16'h0030, 16'h0032, 16'h0034: mask_of = 16'h00FF;
      16'h0042: mask_of = 16'h01FF;
      16'h0044: mask_of = 16'h000C;
      16'h0052: mask_of = 16'h3FFF;
      default: mask_of = 16'hFFFF;
    endcase
  endfunction

  task automatic check(input string name, input sfr_word_t seen, input sfr_word_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run;
  end

  ////////////////////////////////////////////////////////////
  // Tests
  initial begin
    rst_n = 1'b0;
    void'($urandom(33));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 22; i++) begin
      i_core.get(regs[i], 1'b0, q, v);
      check("rd_valid", {15'h0, v}, 16'h0001);
      check("reset", q, (regs[i] == 16'h001E) ? 16'h0800 : 16'h0000);
    end
    $display("test reset done");
    for (i = 0; i < 25; i++) begin
      d = 16'($urandom);
      i_core.put(regs[i], d, 1'b0);
      i_core.get(regs[i], 1'b0, q, v);
      check("word", q, d & mask_of(regs[i]));
    end
    $display("test word done");
    for (i = 0; i < 22; i++) begin
      i_core.get(regs[i], 1'b0, old, v);
      d = 16'($urandom);
      i_core.put(regs[i] | 16'h0001, d, 1'b1);
      e = {d[7:0], old[7:0]} & mask_of(regs[i]);
      d = 16'($urandom);
      i_core.put(regs[i], d, 1'b1);
      e = {e[15:8], d[7:0]} & mask_of(regs[i]);
      i_core.get(regs[i], 1'b0, q, v);
      check("byte merge", q, e);
      i_core.get(regs[i] | 16'h0001, 1'b1, q, v);
      check("byte read", q, {8'h00, e[15:8]});
    end
    $display("test byte done");
    for (i = 0; i < 8; i++) begin
      d = 16'h0400 + {7'h00, 8'($urandom), 1'b0};
      i_core.put(d, 16'($urandom), 1'b0);
      i_core.get(d, 1'b0, q, v);
      check("empty read", q, 16'h0000);
      check("empty hit", {15'h0, sfr_hit}, 16'h0000);
    end
    i_core.put(16'h0008, 16'h1234, 1'b0);
    i_core.get(16'h0008, 1'b0, q, v);
    check("gap read", q, 16'h0000);
    check("gap hit", {15'h0, sfr_hit}, 16'h0001);
    i_core.get(16'h0022, 1'b0, q, v);
    check("unused read", q, 16'h0000);
    i_core.put(16'h0042, 16'h0000, 1'b0);
    i_core.put(16'h0842, 16'h00FF, 1'b0);
    i_core.get(16'h0042, 1'b0, q, v);
    check("outside region", q, 16'h0000);
    i_core.get(16'h0842, 1'b0, q, v);
    check("outside read", q, 16'h0000);
    check("outside hit", {15'h0, sfr_hit}, 16'h0000);
    $display("test map done");
    i_core.put(16'h0002, 16'hA5A5, 1'b0);
    i_core.put(16'h0003, 16'h5A5A, 1'b0);
    check("addr_error", {15'h0, addr_error}, 16'h0001);
    i_core.get(16'h0002, 1'b0, q, v);
    check("misaligned kept", q, 16'hA5A5);
    check("addr_error clear", {15'h0, addr_error}, 16'h0000);
    $display("test align done");
    i_core.put(16'h0044, 16'hFFFF, 1'b0);
    check("window on", {15'h0, program_window_enable}, 16'h0001);
    i_core.put(16'h0042, 16'h00E0, 1'b0);
    check("priority", {12'h000, priority_level}, 16'h000F);
    i_core.put(16'h0044, 16'h0000, 1'b0);
    check("window off", {15'h0, program_window_enable}, 16'h0000);
    check("priority low", {12'h000, priority_level}, 16'h0007);
    $display("test control done");
    i_core.put(16'h001C, 16'hFFFF, 1'b0);
    i_core.put(16'h0044, 16'h000C, 1'b0);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    i_core.get(16'h001E, 1'b0, q, v);
    check("rereset w15", q, 16'h0800);
    i_core.get(16'h001C, 1'b0, q, v);
    check("rereset w14", q, 16'h0000);
    check("rereset window", {15'h0, program_window_enable}, 16'h0000);
    check("rereset priority", {12'h000, priority_level}, 16'h0000);
    $display("test rereset done");
    complete_run;
  end
endmodule // tb_core_sfr_space_decoder
